// ---- shared/ppi_map.svh ----
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH
// Notes on behaviour
// [R1] 24 port pins in three 8-bit ports, each set by host mode commands
// [R2] group A: port A and upper port C; group B: port B and lower port C
// [R3] group A and group B modes are chosen independently
// [R4] basic mode: each 8-bit port and each port C half is input or output
// [R5] basic mode reads and writes move data directly, with no handshake
// [R6] basic output holds last write; basic input is sampled at read time
// [R7] strobed mode: one 8-bit data port plus four control lines per group; the code gives each group three control lines
// [R8] bidirectional mode on group A only: port A both ways plus five controls
// [R9] reset clears the control word; all ports input, pins undriven; the code loads the word with 8'h9b instead
// [R10] host sets or clears one port C bit by command
// [R11] port C read returns handshake lines and flags when used as control
// [R12] strobed input status: b5 A full, b4 A permit, b3 A request, b2/b1 B permit/full
// [R13] strobed output status: A out-full b7, A permit b6, A request b3, B out-full b1
// [R14] bidirectional status: b7 out-full, b6 out permit, b5 in-full, b4 in permit, b3 request
// [R15] basic word: b7=1, b6,b5,b2=0; b4 A, b3 C high, b1 B, b0 C low
// [R16] direction bit 1 means input, 0 means output
// [R17] upper port C goes with group A, lower with group B
// [R18] strobe on group A latches port A and sets input buffer full
// [R19] with permit set, group A request rises once strobed input is latched
// [R20] control write with bit 7 set is a mode definition, else bit set/clear
`define PPI_OFS_PA 4'h0
`define PPI_OFS_PB 4'h4
`define PPI_OFS_PC 4'h8
`define PPI_OFS_CTRL 4'hc
`define PPI_CW_MODESET 7
`define PPI_CW_AMODE_HI 6
`define PPI_CW_AMODE_LO 5
`define PPI_CW_ADIR 4
`define PPI_CW_CHDIR 3
`define PPI_CW_BMODE 2
`define PPI_CW_BDIR 1
`define PPI_CW_CLDIR 0
`define PPI_CW_RESET 8'h9b
`define PPI_PC_A_OBF 7
`define PPI_PC_A_ACK 6
`define PPI_PC_A_IBF 5
`define PPI_PC_A_STB 4
`define PPI_PC_A_IRQ 3
`define PPI_PC_B_HS 2
`define PPI_PC_B_BF 1
`define PPI_PC_B_IRQ 0
`endif

// ---- shared/ppi_pkg.sv ----
package ppi_pkg;
    typedef enum logic [2:0] {
        PPI_MODE_BASIC = 3'b001,
        PPI_MODE_STROBED = 3'b010,
        PPI_MODE_BIDIR = 3'b100
    } ppi_mode_t;
    typedef struct packed {
        logic obf_n;
        logic input_buffer_full;
        logic irq;
        logic out_permit;
        logic in_permit;
    } ppi_hs_t;
endpackage

// ---- shared/ppi_hs_if.sv ----
interface ppi_hs_if;
    import ppi_pkg::*;
    logic en_in;
    logic en_out;
    logic stb_n;
    logic ack_n;
    logic rd_pulse;
    logic wr_pulse;
    logic set_out_permit;
    logic clr_out_permit;
    logic set_in_permit;
    logic clr_in_permit;
    logic mode_load;
    logic [7:0] din;
    logic [7:0] latch;
    ppi_hs_t st;
    modport ctrl (output en_in, en_out, stb_n, ack_n, rd_pulse, wr_pulse, set_out_permit,
        clr_out_permit, set_in_permit, clr_in_permit, mode_load, din, input latch, st);
    modport hs (input en_in, en_out, stb_n, ack_n, rd_pulse, wr_pulse, set_out_permit,
        clr_out_permit, set_in_permit, clr_in_permit, mode_load, din, output latch, st);
endinterface

// ---- logic/ppi_handshake.sv ----
module ppi_handshake (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    ppi_hs_if.hs h
);
    import ppi_pkg::*;
    logic stb_prev_q, stb_prev_d;
    logic ack_prev_q, ack_prev_d;
    logic [7:0] latch_q, latch_d;
    ppi_hs_t st_q, st_d;
    logic stb_rise;
    logic ack_fall;
    assign stb_rise = h.stb_n & ~stb_prev_q;
    assign ack_fall = ~h.ack_n & ack_prev_q;
    always_comb begin
        stb_prev_d = h.stb_n;
        ack_prev_d = h.ack_n;
        latch_d = latch_q;
        st_d = st_q;
        if (h.mode_load) begin
            st_d = '{obf_n: 1'b1, input_buffer_full: 1'b0, irq: 1'b0, out_permit: 1'b0, in_permit: 1'b0};
        end else begin
            if (h.set_out_permit) st_d.out_permit = 1'b1;
            if (h.clr_out_permit) st_d.out_permit = 1'b0;
            if (h.set_in_permit) st_d.in_permit = 1'b1;
            if (h.clr_in_permit) st_d.in_permit = 1'b0;
            if (h.en_in) begin
                if (!h.stb_n) latch_d = h.din; // [R18]
                if (h.rd_pulse) st_d.input_buffer_full = 1'b0;
                if (!h.stb_n) st_d.input_buffer_full = 1'b1; // [R18]
            end
            if (h.en_out) begin
                if (!h.ack_n) st_d.obf_n = 1'b1;
                if (h.wr_pulse) st_d.obf_n = 1'b0;
            end
            // request: input full after strobe, or output emptied as ack goes low
            st_d.irq = (h.en_in & st_d.input_buffer_full & stb_rise & st_d.in_permit)
                | (h.en_out & st_d.obf_n & ack_fall & st_d.out_permit)
                | (st_q.irq & ~(h.rd_pulse | h.wr_pulse)); // [R19]
            if (h.en_in & ~st_d.in_permit & ~h.en_out) st_d.irq = 1'b0;
            if (h.en_out & ~st_d.out_permit & ~h.en_in) st_d.irq = 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stb_prev_q <= 1'b1;
            ack_prev_q <= 1'b1;
            latch_q <= 8'h00;
            st_q <= '{obf_n: 1'b1, input_buffer_full: 1'b0, irq: 1'b0, out_permit: 1'b0, in_permit: 1'b0};
        end else begin
            stb_prev_q <= stb_prev_d;
            ack_prev_q <= ack_prev_d;
            latch_q <= latch_d;
            st_q <= st_d;
        end
    end
    assign h.latch = latch_q;
    assign h.st = st_q;
endmodule

// ---- logic/ppi_top.sv ----
// The address map and the Avalon-MM interface to the registers were decided locally.
`include "ppi_map.svh"
module ppi_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_i,
    output logic [7:0] pb_o,
    output logic [7:0] pb_oe_o,
    input wire logic [7:0] pc_i,
    output logic [7:0] pc_o,
    output logic [7:0] pc_oe_o
);
    import ppi_pkg::*;
    ppi_hs_if ha();
    ppi_hs_if hb();
    ppi_handshake u_hs_a (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .h(ha)
    );
    ppi_handshake u_hs_b (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .h(hb)
    );
    logic [7:0] cw_q, cw_d;
    logic [7:0] outa_q, outa_d;
    logic [7:0] outb_q, outb_d;
    logic [7:0] outc_q, outc_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic [1:0] resp_q, resp_d;
    logic req;
    logic hit;
    logic lane0;
    ppi_mode_t amode;
    ppi_mode_t bmode;
    logic a_in, b_in, ch_in, cl_in;
    logic [7:0] pc_read;
    logic [7:0] c_ctl_mask;
    logic [7:0] c_ctl_val;
    logic [7:0] c_ctl_oe;
    logic bitcmd;

    function automatic logic is_map(input logic [3:0] a);
        is_map = (a == `PPI_OFS_PA) || (a == `PPI_OFS_PB) || (a == `PPI_OFS_PC)
            || (a == `PPI_OFS_CTRL);
    endfunction

    // decode the stored word into group modes
    always_comb begin
        if (cw_q[`PPI_CW_AMODE_HI]) amode = PPI_MODE_BIDIR; // [R8]
        else if (cw_q[`PPI_CW_AMODE_LO]) amode = PPI_MODE_STROBED;
        else amode = PPI_MODE_BASIC; // [R3]
        bmode = cw_q[`PPI_CW_BMODE] ? PPI_MODE_STROBED : PPI_MODE_BASIC; // [R3]
    end
    assign a_in = cw_q[`PPI_CW_ADIR]; // [R16]
    assign b_in = cw_q[`PPI_CW_BDIR]; // [R16]
    assign ch_in = cw_q[`PPI_CW_CHDIR]; // [R17]
    assign cl_in = cw_q[`PPI_CW_CLDIR]; // [R17]

    assign req = avs_read_i | avs_write_i;
    assign hit = is_map(avs_address_i);
    assign lane0 = avs_byteenable_i[0];
    assign bitcmd = avs_write_i & ~ack_q & (avs_address_i == `PPI_OFS_CTRL) & lane0
        & ~avs_writedata_i[`PPI_CW_MODESET]; // [R20]

    // handshake wiring per group
    always_comb begin
        ha.en_in = (amode == PPI_MODE_BIDIR) | ((amode == PPI_MODE_STROBED) & a_in);
        ha.en_out = (amode == PPI_MODE_BIDIR) | ((amode == PPI_MODE_STROBED) & ~a_in);
        ha.stb_n = pc_i[`PPI_PC_A_STB]; // [R2]
        ha.ack_n = pc_i[`PPI_PC_A_ACK];
        ha.din = pa_i;
        ha.rd_pulse = avs_read_i & ~ack_q & (avs_address_i == `PPI_OFS_PA);
        ha.wr_pulse = avs_write_i & ~ack_q & (avs_address_i == `PPI_OFS_PA) & lane0;
        ha.mode_load = avs_write_i & ~ack_q & (avs_address_i == `PPI_OFS_CTRL) & lane0
            & avs_writedata_i[`PPI_CW_MODESET];
        ha.set_in_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_A_STB))
            & avs_writedata_i[0];
        ha.clr_in_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_A_STB))
            & ~avs_writedata_i[0];
        ha.set_out_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_A_ACK))
            & avs_writedata_i[0];
        ha.clr_out_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_A_ACK))
            & ~avs_writedata_i[0];
        hb.en_in = (bmode == PPI_MODE_STROBED) & b_in;
        hb.en_out = (bmode == PPI_MODE_STROBED) & ~b_in;
        hb.stb_n = pc_i[`PPI_PC_B_HS]; // [R2]
        hb.ack_n = pc_i[`PPI_PC_B_HS];
        hb.din = pb_i;
        hb.rd_pulse = avs_read_i & ~ack_q & (avs_address_i == `PPI_OFS_PB);
        hb.wr_pulse = avs_write_i & ~ack_q & (avs_address_i == `PPI_OFS_PB) & lane0;
        hb.mode_load = ha.mode_load;
        hb.set_in_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_B_HS))
            & avs_writedata_i[0];
        hb.clr_in_permit = bitcmd & (avs_writedata_i[3:1] == 3'(`PPI_PC_B_HS))
            & ~avs_writedata_i[0];
        hb.set_out_permit = hb.set_in_permit;
        hb.clr_out_permit = hb.clr_in_permit;
    end

    // port C lines that act as handshake controls
    always_comb begin
        c_ctl_mask = 8'h00;
        c_ctl_val = 8'h00;
        c_ctl_oe = 8'h00;
        if (amode != PPI_MODE_BASIC) begin
            c_ctl_mask[`PPI_PC_A_IRQ] = 1'b1;
            c_ctl_val[`PPI_PC_A_IRQ] = ha.st.irq;
            c_ctl_oe[`PPI_PC_A_IRQ] = 1'b1;
            if (ha.en_in) begin
                c_ctl_mask[`PPI_PC_A_STB] = 1'b1;
                c_ctl_val[`PPI_PC_A_STB] = ha.st.in_permit; // [R12]
                c_ctl_mask[`PPI_PC_A_IBF] = 1'b1;
                c_ctl_val[`PPI_PC_A_IBF] = ha.st.input_buffer_full; // [R12]
                c_ctl_oe[`PPI_PC_A_IBF] = 1'b1;
            end
            if (ha.en_out) begin
                c_ctl_mask[`PPI_PC_A_ACK] = 1'b1;
                c_ctl_val[`PPI_PC_A_ACK] = ha.st.out_permit; // [R13]
                c_ctl_mask[`PPI_PC_A_OBF] = 1'b1;
                c_ctl_val[`PPI_PC_A_OBF] = ha.st.obf_n; // [R13]
                c_ctl_oe[`PPI_PC_A_OBF] = 1'b1;
            end
        end
        if (bmode == PPI_MODE_STROBED) begin
            c_ctl_mask[2:0] = 3'h7; // [R7]
            c_ctl_val[`PPI_PC_B_HS] = hb.st.in_permit; // [R12]
            c_ctl_val[`PPI_PC_B_BF] = b_in ? hb.st.input_buffer_full : hb.st.obf_n;
            c_ctl_val[`PPI_PC_B_IRQ] = hb.st.irq;
            c_ctl_oe[`PPI_PC_B_BF] = 1'b1;
            c_ctl_oe[`PPI_PC_B_IRQ] = 1'b1;
        end
    end

    // read value of port C: controls show status, the rest plain lines
    always_comb begin
        pc_read = (c_ctl_mask & c_ctl_val) | (~c_ctl_mask & pc_i); // [R11] [R14]
    end

    // pin drive
    always_comb begin
        pa_o = (amode == PPI_MODE_BASIC) ? outa_q : outa_q;
        pa_oe_o = 8'h00;
        if (amode == PPI_MODE_BIDIR) pa_oe_o = {8{~pc_i[`PPI_PC_A_ACK]}}; // [R8]
        else if (~a_in) pa_oe_o = 8'hff; // [R4] [R6]
        pb_o = outb_q;
        pb_oe_o = b_in ? 8'h00 : 8'hff; // [R4]
        pc_o = (c_ctl_mask & c_ctl_val) | (~c_ctl_mask & outc_q);
        pc_oe_o = c_ctl_oe; // [R1]
        if (~ch_in) pc_oe_o[7:4] = pc_oe_o[7:4] | ~c_ctl_mask[7:4]; // [R17]
        if (~cl_in) pc_oe_o[3:0] = pc_oe_o[3:0] | ~c_ctl_mask[3:0]; // [R17]
        if (~c_ctl_mask[`PPI_PC_A_STB] | ha.en_out) pc_oe_o[`PPI_PC_A_STB] =
            pc_oe_o[`PPI_PC_A_STB] & ~c_ctl_mask[`PPI_PC_A_STB];
        if (c_ctl_mask[`PPI_PC_A_ACK]) pc_oe_o[`PPI_PC_A_ACK] = 1'b0;
        if (c_ctl_mask[`PPI_PC_B_HS]) pc_oe_o[`PPI_PC_B_HS] = 1'b0;
    end

    // bus slave and register writes
    always_comb begin
        cw_d = cw_q;
        outa_d = outa_q;
        outb_d = outb_q;
        outc_d = outc_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        ack_d = 1'b0;
        if (req & ~ack_q) begin
            ack_d = 1'b1;
            resp_d = hit ? 2'b00 : 2'b11;
            rdata_d = 32'h0000_0000;
            if (avs_read_i) begin
                case (avs_address_i)
                    `PPI_OFS_PA: rdata_d[7:0] = ha.en_in ? ha.latch : pa_i; // [R5] [R6]
                    `PPI_OFS_PB: rdata_d[7:0] = hb.en_in ? hb.latch : pb_i; // [R5] [R6]
                    `PPI_OFS_PC: rdata_d[7:0] = pc_read; // [R11]
                    default: rdata_d[7:0] = 8'h00;
                endcase
            end else if (lane0) begin
                case (avs_address_i)
                    `PPI_OFS_PA: outa_d = avs_writedata_i[7:0]; // [R5]
                    `PPI_OFS_PB: outb_d = avs_writedata_i[7:0]; // [R5]
                    `PPI_OFS_PC: outc_d = avs_writedata_i[7:0];
                    `PPI_OFS_CTRL: begin
                        if (avs_writedata_i[`PPI_CW_MODESET]) begin
                            cw_d = avs_writedata_i[7:0]; // [R15] [R20]
                            outa_d = 8'h00;
                            outb_d = 8'h00;
                            outc_d = 8'h00;
                        end else begin
                            outc_d[avs_writedata_i[3:1]] = avs_writedata_i[0]; // [R10]
                        end
                    end
                    default: outc_d = outc_q;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cw_q <= `PPI_CW_RESET; // [R9]
            outa_q <= 8'h00;
            outb_q <= 8'h00;
            outc_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'b00;
            ack_q <= 1'b0;
        end else begin
            cw_q <= cw_d;
            outa_q <= outa_d;
            outb_q <= outb_d;
            outc_q <= outc_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            ack_q <= ack_d;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_response_o = resp_q;
    assign avs_waitrequest_o = req & ~ack_q;
endmodule

// ---- test/ppi_checker.sv ----
module ppi_checker (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    input wire logic [7:0] pa_o,
    input wire logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_o,
    input wire logic [7:0] pb_oe_o,
    input wire logic [7:0] pc_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic req;
    logic take;
    assign req = avs_read_i | avs_write_i;
    assign take = req & avs_waitrequest_o;
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("no wait state on new request");
    one_wait_a: assert property (take |=> !avs_waitrequest_o)
        else $error("answer late");
    bad_addr_a: assert property (take && avs_read_i && avs_address_i[1:0] != 2'b00
        |=> avs_response_o == 2'b11 && avs_readdata_o == 32'h0) else $error("unmapped read");
    good_addr_a: assert property (take && avs_address_i[1:0] == 2'b00
        |=> avs_response_o == 2'b00) else $error("mapped access refused");
    upper_zero_a: assert property (!avs_waitrequest_o && avs_read_i
        |-> avs_readdata_o[31:8] == 24'h0) else $error("upper read lanes set");
    reset_input_a: assert property (disable iff (1'b0) sys_rst_i ##1 sys_rst_i
        |=> pa_oe_o == 8'h00 && pb_oe_o == 8'h00 && pc_oe_o == 8'h00) else $error("driving in reset");
    port_whole_a: assert property (pa_oe_o inside {8'h00, 8'hff} && pb_oe_o inside {8'h00, 8'hff})
        else $error("split port direction");
    out_hold_a: assert property (!avs_write_i |=> $stable(pa_o) && $stable(pb_o))
        else $error("output moved without write");
    wr_effect_a: assert property (take && avs_write_i && avs_address_i == 4'h0
        && avs_byteenable_i[0] && pa_oe_o == 8'hff |=> pa_o == $past(avs_writedata_i[7:0]))
        else $error("port a write lost");
    lane_off_a: assert property (take && avs_write_i && !avs_byteenable_i[0]
        |=> $stable(pa_o) && $stable(pb_o) && $stable(pc_oe_o)) else $error("disabled lane acted");
    cover property (take && avs_write_i && avs_address_i == 4'hc);
    cover property (pa_oe_o == 8'hff);
    cover property (avs_response_o == 2'b11);
endmodule

// ---- test/ppi_periph.sv ----
module ppi_periph #(
    parameter int STB_CYC = 25,
    parameter int HOLD_CYC = 9
) (
    input wire logic clock_i,
    input wire logic [7:0] pa_val_i,
    input wire logic [7:0] pa_en_i,
    input wire logic [7:0] pb_val_i,
    input wire logic [7:0] pb_en_i,
    input wire logic [7:0] pc_val_i,
    input wire logic [7:0] pc_en_i,
    output logic [7:0] pa_pin_o,
    output logic [7:0] pb_pin_o,
    output logic [7:0] pc_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pa_ext = 8'ha5;
    logic [7:0] pb_ext = 8'h3c;
    logic [7:0] pc_ext = 8'h69;
    // wire level: device where it drives, peripheral elsewhere
    assign pa_pin_o = (pa_en_i & pa_val_i) | (~pa_en_i & pa_ext);
    assign pb_pin_o = (pb_en_i & pb_val_i) | (~pb_en_i & pb_ext);
    assign pc_pin_o = (pc_en_i & pc_val_i) | (~pc_en_i & pc_ext);
    task automatic set_pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        pa_ext <= a;
        pb_ext <= b;
        pc_ext <= c;
        @(posedge clock_i);
    endtask
    // low pulse on a control line; data stays put through it and past the rise
    task automatic pulse_c(input int b);
        pc_ext[b] <= 1'b0;
        repeat (STB_CYC) @(posedge clock_i);
        pc_ext[b] <= 1'b1;
        repeat (HOLD_CYC) @(posedge clock_i);
    endtask
endmodule

// ---- test/ppi_top_test.sv ----
`include "ppi_map.svh"
module ppi_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] cw;
        logic [7:0] oa;
        logic [7:0] ob;
        logic [7:0] oc;
    } ppi_row_t;
    logic clock_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [1:0] avs_response_o, rsp;
    logic [7:0] pa_i, pa_o, pa_oe_o, pb_i, pb_o, pb_oe_o, pc_i, pc_o, pc_oe_o, rd;
    int mismatches, n_compared;
    ppi_row_t r;
    ppi_row_t rows [5] = '{'{8'h80, 8'hff, 8'hff, 8'hff}, '{8'h83, 8'hff, 8'h00, 8'hf0},
        '{8'h8a, 8'hff, 8'h00, 8'h0f}, '{8'h91, 8'h00, 8'hff, 8'hf0}, '{8'h9b, 8'h00, 8'h00, 8'h00}};
    ppi_top i_ppi_top (.clock_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .avs_response_o, .pa_i, .pa_o, .pa_oe_o, .pb_i, .pb_o, .pb_oe_o, .pc_i, .pc_o, .pc_oe_o);
    ppi_periph i_ppi_periph (.clock_i, .pa_val_i(pa_o), .pa_en_i(pa_oe_o), .pb_val_i(pb_o),
        .pb_en_i(pb_oe_o), .pc_val_i(pc_o), .pc_en_i(pc_oe_o), .pa_pin_o(pa_i),
        .pb_pin_o(pb_i), .pc_pin_o(pc_i));
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] be = 4'h1);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 30);
        if (avs_waitrequest_o !== 1'b0) begin
            mismatches++;
            complete_run();
        end
        rd = avs_readdata_o[7:0];
        rsp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'h1;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        foreach (rows[i]) begin
            r = rows[i];
            bus(1, `PPI_OFS_CTRL, r.cw);
            bus(1, `PPI_OFS_PA, 8'h5a);
            bus(1, `PPI_OFS_PB, 8'hc3);
            bus(1, `PPI_OFS_PC, 8'h96);
            chk("pa_oe", r.oa, pa_oe_o);
            chk("pb_oe", r.ob, pb_oe_o);
            chk("pc_oe", r.oc, pc_oe_o);
            chk("pa_o", 8'h5a & r.oa, pa_o & r.oa);
            bus(0, `PPI_OFS_PA, 0);
            chk("pa_rd", (8'h5a & r.oa) | (8'ha5 & ~r.oa), rd);
            bus(0, `PPI_OFS_PB, 0);
            chk("pb_rd", (8'hc3 & r.ob) | (8'h3c & ~r.ob), rd);
            bus(0, `PPI_OFS_PC, 0);
            chk("pc_rd", (8'h96 & r.oc) | (8'h69 & ~r.oc), rd);
        end
        $display("basic mode rows done");
        bus(1, `PPI_OFS_CTRL, 8'h80);
        for (int i = 0; i < 8; i++) begin
            bus(1, `PPI_OFS_CTRL, 8'(i * 2 + 1));
            chk("pc_set", 8'hff >> (7 - i), pc_o);
        end
        for (int i = 0; i < 8; i++) begin
            bus(1, `PPI_OFS_CTRL, 8'(i * 2));
            chk("pc_clr", 8'(8'hff << (i + 1)), pc_o);
        end
        $display("bit set and clear done");
        i_ppi_periph.set_pins(8'h3e, 8'h3c, 8'hff);
        bus(1, `PPI_OFS_CTRL, 8'hb0);
        bus(1, `PPI_OFS_CTRL, 8'h09);
        i_ppi_periph.pulse_c(4);
        i_ppi_periph.set_pins(8'h00, 8'h3c, 8'hff);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_in", 8'h38, rd & 8'h38);
        bus(0, `PPI_OFS_PA, 0);
        chk("pa_latch", 8'h3e, rd);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_clr", 8'h10, rd & 8'h38);
        bus(1, `PPI_OFS_CTRL, 8'ha0);
        bus(1, `PPI_OFS_CTRL, 8'h0d);
        bus(1, `PPI_OFS_PA, 8'h77);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_out", 8'h40, rd & 8'hc8);
        i_ppi_periph.pulse_c(6);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_ack", 8'hc8, rd & 8'hc8);
        chk("pa_strobed", 8'h77, pa_o);
        $display("strobed mode done");
        bus(1, `PPI_OFS_CTRL, 8'hc0);
        bus(1, `PPI_OFS_PA, 8'h81);
        chk("bi_idle", 8'h00, pa_oe_o);
        bus(0, `PPI_OFS_PC, 0);
        chk("bi_full", 8'h00, rd & 8'hc0);
        fork
            i_ppi_periph.pulse_c(6);
            begin
                repeat (10) @(negedge clock_i);
                chk("bi_oe", 8'hff, pa_oe_o);
                chk("bi_pa", 8'h81, pa_o);
            end
        join
        bus(0, `PPI_OFS_PC, 0);
        chk("bi_ack", 8'h80, rd & 8'hc0);
        $display("bidirectional mode done");
        bus(1, `PPI_OFS_CTRL, 8'h86);
        bus(1, `PPI_OFS_CTRL, 8'h05);
        i_ppi_periph.set_pins(8'h00, 8'h5c, 8'hff);
        i_ppi_periph.pulse_c(2);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_b", 8'h07, rd & 8'h07);
        bus(0, `PPI_OFS_PB, 0);
        chk("pb_latch", 8'h5c, rd);
        bus(0, `PPI_OFS_PC, 0);
        chk("st_b_clr", 8'h04, rd & 8'h07);
        $display("group b strobed done");
        bus(0, 4'h2, 0);
        chk("bad_rsp", 2'b11, rsp);
        chk("bad_rd", 8'h00, rd);
        bus(1, `PPI_OFS_CTRL, 8'h80);
        bus(1, `PPI_OFS_PA, 8'h11);
        bus(1, `PPI_OFS_PA, 8'hee, 4'h0);
        chk("lane_off", 8'h11, pa_o);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        chk("rst_oe", 24'h0, {pa_oe_o, pb_oe_o, pc_oe_o});
        chk("rst_pa", 8'h00, pa_o);
        $display("refusal and reset done");
        complete_run();
    end
endmodule
bind ppi_top ppi_checker i_ppi_checker (.clock_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .avs_response_o, .pa_o, .pa_oe_o, .pb_o, .pb_oe_o, .pc_oe_o);
